// File: design/sfr_pkg.sv
// package: command layout, register addresses, flag layouts and timing
package sfr_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned FILT_US         = 100;
    localparam int unsigned FILT_CYC        = FILT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RSTPULSE_MS     = 100;
    localparam int unsigned RSTPULSE_CYC    = RSTPULSE_MS * (CLK_HZ / 1000);

    localparam int          CMD_W           = 16;
    localparam int          TYPE_HI         = 15;
    localparam int          TYPE_LO         = 14;
    localparam int          ADDR_HI         = 13;
    localparam int          ADDR_LO         = 9;
    localparam int          READ_BIT        = 8;
    localparam int          HALF_BIT        = 7;

    localparam logic [1:0]  TYPE_FLAGS      = 2'h3;
    localparam logic [1:0]  TYPE_LIVE       = 2'h0;

    localparam logic [4:0]  ADDR_REG        = 5'h0f;
    localparam logic [4:0]  ADDR_CAN        = 5'h10;
    localparam logic [4:0]  ADDR_IO         = 5'h11;
    localparam logic [4:0]  ADDR_INT        = 5'h12;

    localparam logic [15:0] FLAGS_RESET     = 16'h0000;
    localparam logic [7:0]  MISO_RESET      = 8'h00;
    localparam int          NFLAG           = 64;

    // arbitrary neutral identity, not a real part code
    localparam logic [7:0]  ID_DEFAULT      = 8'h5a;

    // flag index base for each 16-bit flag group (low byte, then high byte)
    localparam int          IDX_REG         = 0;
    localparam int          IDX_CAN         = 16;
    localparam int          IDX_IO          = 32;
    localparam int          IDX_INT         = 48;
    // supply flags that pass the 100 us filter: reg group bits 0..7
    localparam int          NFILT           = 8;
    // reset-pin short pulse flag: int group high byte bit 2
    localparam int          IDX_RST_SHORT   = 58;

    typedef struct packed {
        logic [1:0] kind;
        logic [4:0] addr;
        logic       rd;
        logic       half;
    } sfr_cmd_t;

    typedef enum logic [1:0] {SFR_IDLE, SFR_SHIFT, SFR_DONE} sfr_state_t;
endpackage

// File: design/sfr_filter.sv
// filter: level must persist more than a set number of cycles
`timescale 1ns/1ns
`default_nettype none
module sfr_filter
    import sfr_pkg::*;
#(
    parameter int unsigned CYC = 2000
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic level_in,
    output var  logic level_out
);
    logic [$clog2(CYC+2)-1:0] count;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count     <= '0;
            level_out <= 1'b0;
        end else if (!level_in) begin
            count     <= '0;
            level_out <= 1'b0;
        end else if (count > ($clog2(CYC+2))'(CYC)) begin
            level_out <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule // sfr_filter
`default_nettype wire

// File: design/sfr_readout.sv
// flag and status read-back over the serial link
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - type bits 15:14 equal to 11 select latched fault flags.
// - type 00 in bits 15:14 selects live pin, identity or transceiver state.
// - command bits 13 to 9 hold the register address.
// - reads are never parity checked.
// - a fault sets its flag, which clears only when read after recovery.
// - supply low flags set only after more than 100 us beyond threshold.
// - a reset pin low pulse shorter than 100 ms raises its own flag.
module sfr_readout
    import sfr_pkg::*;
#(
    parameter int unsigned FILTER_CYC = FILT_CYC,
    parameter int unsigned RSTP_CYC   = RSTPULSE_CYC,
    parameter logic [7:0]  DEV_ID     = ID_DEFAULT
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             sclk,
    input  wire logic             chip_select_n,
    input  wire logic             mosi,
    output var  logic             miso,
    output var  logic             miso_oe,
    input  wire logic [NFLAG-1:0] fault_in,
    input  wire logic [7:0]       can_live,
    input  wire logic [7:0]       io_levels,
    input  wire logic             reset_pin_n
);
    logic        rst_m, rst_n;
    logic [2:0]  sclk_s, cs_s, mosi_s, rpin_s;
    logic [15:0] shreg;
    logic [4:0]  bitcnt;
    logic [7:0]  resp;
    logic [NFLAG-1:0] flags, cause, clr;
    logic [NFILT-1:0] filt_out;
    logic        rst_short;
    logic        shift_done;
    logic [$clog2(RSTP_CYC+2)-1:0] rcnt;
    sfr_state_t  state;
    sfr_cmd_t    cmd;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // two flops then an edge history stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s <= 3'h0;
            cs_s   <= 3'h7;
            mosi_s <= 3'h0;
            rpin_s <= 3'h7;
        end else begin
            sclk_s <= {sclk_s[1:0], sclk};
            cs_s   <= {cs_s[1:0], chip_select_n};
            mosi_s <= {mosi_s[1:0], mosi};
            rpin_s <= {rpin_s[1:0], reset_pin_n};
        end
    end

    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];
    wire cs_act    = ~cs_s[1];

    function automatic logic [7:0] sfr_byte(input logic [NFLAG-1:0] v,
                                            input int base,
                                            input logic hi);
        sfr_byte = hi ? v[base+8 +: 8] : v[base +: 8];
    endfunction

    function automatic int sfr_base(input logic [4:0] a);
        case (a)
            ADDR_REG: sfr_base = IDX_REG;
            ADDR_CAN: sfr_base = IDX_CAN;
            ADDR_IO:  sfr_base = IDX_IO;
            ADDR_INT: sfr_base = IDX_INT;
            default:  sfr_base = -1;
        endcase
    endfunction

    assign cmd = '{kind: shreg[TYPE_HI:TYPE_LO],
                   addr: shreg[ADDR_HI:ADDR_LO],
                   rd:   shreg[READ_BIT],
                   half: shreg[HALF_BIT]};

    // frame sequencing: shift in on rise, shift out on fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state  <= SFR_IDLE;
            shreg  <= 16'h0000;
            bitcnt <= 5'h00;
        end else if (!cs_act) begin
            state  <= SFR_IDLE;
            bitcnt <= 5'h00;
        end else begin
            case (state)
                SFR_IDLE: begin
                    state  <= SFR_SHIFT;
                    bitcnt <= 5'h00;
                end
                SFR_SHIFT: begin
                    if (sclk_rise) begin
                        shreg  <= {shreg[14:0], mosi_s[1]};
                        bitcnt <= bitcnt + 5'h01;
                        if (bitcnt == 5'h0f)
                            state <= SFR_DONE;
                    end
                end
                SFR_DONE: state <= SFR_DONE;
                default:  state <= SFR_IDLE;
            endcase
        end
    end

    // response byte selection, no parity check on reads
    logic [7:0] next_resp;
    always_comb begin
        next_resp = 8'h00;
        if (cmd.kind == TYPE_FLAGS
            && sfr_base(cmd.addr) >= 0) begin
            next_resp = sfr_byte(flags, sfr_base(cmd.addr),
                                 cmd.half);
        end else if (cmd.kind == TYPE_LIVE && cmd.half) begin
            case (cmd.addr)
                ADDR_CAN: next_resp = can_live;
                ADDR_IO:  next_resp = io_levels;
                ADDR_INT: next_resp = DEV_ID;
                default:  next_resp = 8'h00;
            endcase
        end
    end

    wire frame_end = (state == SFR_DONE) && !cs_s[2] && cs_s[1];
    wire read_ok   = cmd.rd && cmd.kind == TYPE_FLAGS;

    // strobe once the 16th bit sits in the shift register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            shift_done <= 1'b0;
        else
            shift_done <= cs_act && state == SFR_SHIFT && sclk_rise
                          && bitcnt == 5'h0f;
    end

    // load the byte, then one new bit after each sclk fall
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resp    <= MISO_RESET;
            miso    <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= cs_act;
            if (shift_done) begin
                resp <= next_resp;
                miso <= next_resp[7];
            end else if (state == SFR_DONE && cs_act && sclk_fall) begin
                miso <= resp[6];
                resp <= {resp[6:0], 1'b0};
            end else if (!cs_act) begin
                miso <= 1'b0;
            end
        end
    end

    // reset-pin short low pulse detector
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rcnt      <= '0;
            rst_short <= 1'b0;
        end else begin
            rst_short <= 1'b0;
            if (!rpin_s[1]) begin
                if (rcnt <= ($bits(rcnt))'(RSTP_CYC))
                    rcnt <= rcnt + 1'b1;
            end else begin
                if (!rpin_s[2] && rcnt < ($bits(rcnt))'(RSTP_CYC))
                    rst_short <= 1'b1;
                rcnt <= '0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NFILT; g++) begin : g_filt
            sfr_filter #(.CYC(FILTER_CYC)) u_filt (
                .clk_sys  (clk_sys),
                .rst_n    (rst_n),
                .level_in (fault_in[g]),
                .level_out(filt_out[g])
            );
        end
    endgenerate

    always_comb begin
        cause = fault_in;
        cause[NFILT-1:0] = filt_out;
        cause[IDX_RST_SHORT] = rst_short;
        clr = '0;
        if (frame_end && read_ok && sfr_base(cmd.addr) >= 0)
            clr[sfr_base(cmd.addr) + (cmd.half ? 8 : 0) +: 8] = 8'hff;
    end

    // latch: set wins over the read clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            flags <= FLAGS_RESET;
        else
            flags <= cause | (flags & ~clr);
    end

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_flag_hold: assert property (
        $rose(flags[0]) |=> flags[0] [*4])
        else $error("flag dropped without read");
    chk_flag_set: assert property (
        cause[5] |=> flags[5])
        else $error("fault did not latch");
    chk_filter_delay: assert property (
        $rose(filt_out[0]) |-> $past(fault_in[0], 5))
        else $error("filter released too early");
    chk_short_rst: assert property (
        rst_short |-> $past(rpin_s[1]) && !$past(rpin_s[2]))
        else $error("short reset flag without release");
    chk_live_id: assert property (
        cmd.kind == TYPE_LIVE && cmd.half && cmd.addr == ADDR_INT
        |-> next_resp == DEV_ID)
        else $error("identity not returned");
    chk_flag_sel: assert property (
        cmd.kind == TYPE_FLAGS && cmd.addr == ADDR_CAN && !cmd.half
        |-> next_resp == flags[IDX_CAN +: 8])
        else $error("wrong flag byte");
    chk_half_sel: assert property (
        cmd.kind == TYPE_FLAGS && cmd.addr == ADDR_IO && cmd.half
        |-> next_resp == flags[IDX_IO+8 +: 8])
        else $error("wrong half byte");
    chk_no_parity: assert property (
        cmd.kind == TYPE_FLAGS && cmd.addr == ADDR_REG && !cmd.half
        |-> next_resp == flags[7:0])
        else $error("read answer gated");
    chk_addr_bad: assert property (
        cmd.kind == TYPE_FLAGS && sfr_base(cmd.addr) < 0
        |-> next_resp == 8'h00)
        else $error("unmapped address answered");

    cov_frame: cover property (@(posedge clk_sys) frame_end && read_ok);
    cov_clear: cover property (@(posedge clk_sys) $fell(flags[IDX_CAN]));
    cov_id:    cover property (@(posedge clk_sys)
        frame_end && cmd.kind == TYPE_LIVE);
endmodule // sfr_readout
`default_nettype wire

// File: dv/sfr_host.sv
// host model: serial master sending commands and reading reply bytes
`timescale 1ns/1ns
`default_nettype none
module sfr_host (
    input  wire logic clk_sys,
    input  wire logic miso,
    output var  logic sclk,
    output var  logic chip_select_n,
    output var  logic mosi
);
    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    // 16 command bits, then 8 reply bits; sclk idles low between frames
    task automatic xfer(input logic [15:0] cmd, output logic [7:0] rsp);
        chip_select_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            // released data line toggles rather than holding a value
            mosi = (i < 16) ? cmd[15-i] : ~mosi;
            step(4);
            sclk = 1'b1;
            step(4);
            if (i >= 15 && i < 23) begin
                rsp = {rsp[6:0], miso};
            end
            sclk = 1'b0;
        end
        step(4);
        chip_select_n = 1'b1;
        mosi = ~mosi;
        step(6);
    endtask
endmodule // sfr_host
`default_nettype wire

// File: dv/tb_top.sv
// testbench: flag and status read-back through the host model
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import sfr_pkg::*;
();
    logic             clk_sys;
    logic             rstn;
    logic             sclk;
    logic             chip_select_n;
    logic             mosi;
    logic             miso;
    logic             miso_oe;
    logic [NFLAG-1:0] fault_in;
    logic [7:0]       can_live;
    logic [7:0]       io_levels;
    logic             reset_pin_n;
    logic [7:0]       rsp;
    int               fails;
    int               samples_checked;

    sfr_readout #(.FILTER_CYC(4), .RSTP_CYC(50)) u_dut (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .sclk          (sclk),
        .chip_select_n (chip_select_n),
        .mosi          (mosi),
        .miso          (miso),
        .miso_oe       (miso_oe),
        .fault_in      (fault_in),
        .can_live      (can_live),
        .io_levels     (io_levels),
        .reset_pin_n   (reset_pin_n)
    );

    sfr_host u_host (
        .clk_sys       (clk_sys),
        .miso          (miso),
        .sclk          (sclk),
        .chip_select_n (chip_select_n),
        .mosi          (mosi)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] cmd(input logic [1:0] k,
                                        input logic [4:0] a,
                                        input logic       h);
        return {k, a, 1'b1, h, 7'h00};
    endfunction

    // one frame, then the line must be quiet once deselected
    task automatic rd(input logic [15:0] c, input logic [7:0] exp);
        u_host.xfer(c, rsp);
        chk(rsp, exp);
        chk({6'h00, miso_oe, miso}, 8'h00);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        fails++;
        close_out();
    end

    initial begin
        logic [15:0] c;
        rstn = 1'b0;
        fault_in = '0;
        can_live = 8'ha5;
        io_levels = 8'h3c;
        reset_pin_n = 1'b1;
        fails = 0;
        samples_checked = 0;
        cyc(10);
        rstn = 1'b1;
        cyc(6);
        for (int a = 15; a < 19; a++) begin
            for (int h = 0; h < 2; h++) begin
                rd(cmd(TYPE_FLAGS, 5'(a), 1'(h)), 8'h00);
            end
        end
        $display("test reset done");
        rd(cmd(TYPE_LIVE, ADDR_CAN, 1'b1), 8'ha5);
        rd(cmd(TYPE_LIVE, ADDR_IO, 1'b1), 8'h3c);
        rd(cmd(TYPE_LIVE, ADDR_INT, 1'b1), ID_DEFAULT);
        rd(cmd(TYPE_LIVE, ADDR_CAN, 1'b0), 8'h00);
        rd(cmd(2'h1, ADDR_CAN, 1'b1), 8'h00);
        rd(cmd(TYPE_FLAGS, 5'h05, 1'b0), 8'h00);
        $display("test live done");
        // each flag byte: held while present, cleared once read after
        for (int i = 0; i < 8; i++) begin
            c = cmd(TYPE_FLAGS, ADDR_REG + 5'(i / 2), 1'(i % 2));
            fault_in[i*8 +: 8] = 8'h81;
            cyc(12);
            rd(c, 8'h81);
            fault_in = '0;
            cyc(2);
            rd(c, 8'h81);
            rd(c, 8'h00);
        end
        $display("test latch done");
        c = cmd(TYPE_FLAGS, ADDR_REG, 1'b0);
        fault_in[0] = 1'b1;
        cyc(2);
        fault_in[0] = 1'b0;
        cyc(4);
        rd(c, 8'h00);
        fault_in[0] = 1'b1;
        cyc(12);
        fault_in[0] = 1'b0;
        cyc(4);
        rd(c, 8'h01);
        $display("test filter done");
        c = cmd(TYPE_FLAGS, ADDR_INT, 1'b1);
        reset_pin_n = 1'b0;
        cyc(10);
        reset_pin_n = 1'b1;
        cyc(4);
        rd(c, 8'h04);
        rd(c, 8'h00);
        reset_pin_n = 1'b0;
        cyc(70);
        reset_pin_n = 1'b1;
        cyc(4);
        rd(c, 8'h00);
        $display("test reset pin done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
